/* hdl/synth_function_pkg.sv */
// constants for the synthesizer function control latch
package synth_function_pkg;

  // serial word geometry
  localparam int WORD_WIDTH = 24;
  localparam int LATCH_SELECT_WIDTH = 2;

  // two low control bits pick the destination latch
  localparam logic [1:0] SELECT_REFERENCE = 2'h0;
  localparam logic [1:0] SELECT_FEEDBACK = 2'h1;
  localparam logic [1:0] SELECT_FUNCTION = 2'h2;
  localparam logic [1:0] SELECT_INITIALIZE = 2'h3;

  // function word field positions
  localparam int POS_COUNTER_HOLD_RESET = 2;
  localparam int POS_POWERDOWN_REQUEST = 3;
  localparam int POS_MONITOR_SELECT_LSB = 4;
  localparam int POS_MONITOR_SELECT_MSB = 6;
  localparam int POS_DETECTOR_POLARITY = 7;
  localparam int POS_PUMP_OUTPUT_FLOAT = 8;
  localparam int POS_FASTLOCK_ENABLE = 9;
  localparam int POS_FASTLOCK_MODE = 10;
  localparam int POS_TIMEOUT_CODE_LSB = 11;
  localparam int POS_TIMEOUT_CODE_MSB = 14;
  localparam int POS_STEADY_CURRENT_LSB = 15;
  localparam int POS_STEADY_CURRENT_MSB = 17;
  localparam int POS_FAST_CURRENT_LSB = 18;
  localparam int POS_FAST_CURRENT_MSB = 20;
  localparam int POS_POWERDOWN_SYNC = 21;

  // feedback divider word: gain boost bit
  localparam int POS_GAIN_BOOST = 21;

  // function word after reset: everything zero
  localparam logic [23:0] FUNCTION_RESET = 24'h000000;

  // timeout in detector cycles = base + step * code
  localparam int TIMEOUT_WIDTH = 6;
  localparam logic [5:0] TIMEOUT_BASE = 6'h03;
  localparam int TIMEOUT_STEP_SHIFT = 2;

  // monitor output selections
  localparam logic [2:0] MONITOR_FLOAT = 3'h0;
  localparam logic [2:0] MONITOR_LOCK_DETECT = 3'h1;
  localparam logic [2:0] MONITOR_FEEDBACK_DIV = 3'h2;
  localparam logic [2:0] MONITOR_HIGH = 3'h3;
  localparam logic [2:0] MONITOR_REFERENCE_DIV = 3'h4;
  localparam logic [2:0] MONITOR_LOCK_OPEN_DRAIN = 3'h5;
  localparam logic [2:0] MONITOR_SERIAL_OUT = 3'h6;
  localparam logic [2:0] MONITOR_LOW = 3'h7;

endpackage

/* hdl/rise_detect.sv */
// single-cycle pulse on the rising edge of a synchronous level
`timescale 1ns/100ps
module rise_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic level,
  output logic rise
);

  typedef struct packed {
    logic previous;
  } rise_state_type;

  rise_state_type state;
  rise_state_type next_state;

  // remember the level of the last cycle
  always_comb begin
    next_state = state;
    next_state.previous = level;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // a pulse only when the level has just gone high
  assign rise = level & ~state.previous;

endmodule // rise_detect

/* hdl/synth_function_control_latch.sv */
// function word latch, power-down and fast-lock control of the synthesizer
`timescale 1ns/100ps
module synth_function_control_latch #(
  parameter int WORD_WIDTH = synth_function_pkg::WORD_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  // three-wire serial programming port
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_enable,
  // device enable pin, high for normal running
  input wire logic chip_enable,
  // pulse on each phase-detector cycle
  input wire logic detector_tick,
  // pulse on each charge pump event
  input wire logic pump_event,
  // internal signals that the monitor pin can show
  input wire logic lock_detect,
  input wire logic reference_div_out,
  input wire logic feedback_div_out,
  // divider and timer control
  output logic reference_div_hold,
  output logic feedback_div_hold,
  output logic powered_down,
  output logic lock_detect_clear,
  // charge pump control
  output logic pump_float,
  output logic [2:0] pump_current_code,
  output logic fastlock_active,
  output logic detector_polarity_select,
  // monitor output pin as two signals
  output logic monitor_output_pin_out,
  output logic monitor_output_pin_oe_n,
  // current settings for observation
  output logic [2:0] monitor_select,
  output logic gain_boost_bit
);

  typedef struct packed {
    logic [WORD_WIDTH-1:0] shifter;
    logic [WORD_WIDTH-1:0] function_control_word;
    logic gain_boost;
    logic sync_down;
    logic [synth_function_pkg::TIMEOUT_WIDTH-1:0] timeout_count;
    logic timer_running;
    logic init_pulse;
    logic monitor_out;
    logic monitor_oe_n;
  } latch_state_type;

  latch_state_type state;
  latch_state_type next_state;

  logic serial_rise;
  logic load_rise;

  // edge of the shift clock, sampled on the system clock
  // port pins are sampled on clk, so each serial_clock and load_enable
  // level must last at least one cycle to be seen
  rise_detect shift_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(serial_clock),
    .rise(serial_rise)
  );

  // edge of the load strobe
  rise_detect load_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(load_enable),
    .rise(load_rise)
  );

  // named views of the active function word
  // fields come from the active word only, never from the shifter
  logic counter_hold_reset;
  logic powerdown_request;
  logic powerdown_sync_select;
  logic [2:0] monitor_field;
  logic pump_output_float;
  logic fastlock_enable_bit;
  logic fastlock_mode_select;
  logic [3:0] timeout_code;
  logic [2:0] steady_current_code;
  logic [2:0] fast_current_code;

  assign counter_hold_reset =
    state.function_control_word[synth_function_pkg::POS_COUNTER_HOLD_RESET];
  assign powerdown_request =
    state.function_control_word[synth_function_pkg::POS_POWERDOWN_REQUEST];
  assign powerdown_sync_select =
    state.function_control_word[synth_function_pkg::POS_POWERDOWN_SYNC];
  assign monitor_field = state.function_control_word[
    synth_function_pkg::POS_MONITOR_SELECT_MSB:
    synth_function_pkg::POS_MONITOR_SELECT_LSB];
  assign pump_output_float =
    state.function_control_word[synth_function_pkg::POS_PUMP_OUTPUT_FLOAT];
  assign fastlock_enable_bit =
    state.function_control_word[synth_function_pkg::POS_FASTLOCK_ENABLE];
  assign fastlock_mode_select =
    state.function_control_word[synth_function_pkg::POS_FASTLOCK_MODE];
  assign timeout_code = state.function_control_word[
    synth_function_pkg::POS_TIMEOUT_CODE_MSB:
    synth_function_pkg::POS_TIMEOUT_CODE_LSB];
  assign steady_current_code = state.function_control_word[
    synth_function_pkg::POS_STEADY_CURRENT_MSB:
    synth_function_pkg::POS_STEADY_CURRENT_LSB];
  assign fast_current_code = state.function_control_word[
    synth_function_pkg::POS_FAST_CURRENT_MSB:
    synth_function_pkg::POS_FAST_CURRENT_LSB];

  // decode of the word that the load strobe completes
  logic [1:0] latch_select;
  logic load_function;
  logic load_feedback;
  logic load_initialize;
  logic written_gain_boost;

  assign latch_select =
    state.shifter[synth_function_pkg::LATCH_SELECT_WIDTH-1:0];
  assign load_function = load_rise &&
    (latch_select == synth_function_pkg::SELECT_FUNCTION);
  assign load_initialize = load_rise &&
    (latch_select == synth_function_pkg::SELECT_INITIALIZE);
  assign load_feedback = load_rise &&
    (latch_select == synth_function_pkg::SELECT_FEEDBACK);
  assign written_gain_boost =
    state.shifter[synth_function_pkg::POS_GAIN_BOOST];

  // power-down sources
  logic pin_down;
  logic async_down;
  logic any_down;

  assign pin_down = ~chip_enable;
  // programmed bits gated by the pin
  assign async_down = chip_enable & powerdown_request & ~powerdown_sync_select;
  // combinational so the pin acts without waiting a clock;
  // the armed sync term is gated too, so a low pin drops it at once
  assign any_down = pin_down | async_down | (chip_enable & state.sync_down);

  // timer exit is only armed in fast-lock mode two
  logic timer_mode;
  logic timer_expired;
  logic [synth_function_pkg::TIMEOUT_WIDTH-1:0] timeout_load;

  // mode two needs the enable bit
  assign timer_mode = fastlock_enable_bit & fastlock_mode_select;
  // six bits hold the longest span, sixty-three cycles for code 15
  // three plus four per code step
  assign timeout_load = synth_function_pkg::TIMEOUT_BASE +
    synth_function_pkg::TIMEOUT_WIDTH'({timeout_code, 2'h0});
  assign timer_expired = state.timer_running && detector_tick &&
    (state.timeout_count == synth_function_pkg::TIMEOUT_WIDTH'(1));

  // next state of the whole latch
  always_comb begin
    next_state = state;
    // init pulse is one cycle wide by default
    next_state.init_pulse = 1'b0;

    // bits beyond the word length push the oldest out of the top
    // shifting never stops, msb first
    if (serial_rise) begin
      next_state.shifter = {state.shifter[WORD_WIDTH-2:0], serial_data};
    end

    // function and initialize words share the register
    if (load_function || load_initialize) begin
      next_state.function_control_word = state.shifter;
    end
    // initialize word also pulses the divider reset
    if (load_initialize) begin
      next_state.init_pulse = 1'b1;
    end

    // waiting for the pump keeps the output from jumping mid-correction
    // sync power-down waits for a pump event
    if (!chip_enable || !powerdown_request || !powerdown_sync_select) begin
      next_state.sync_down = 1'b0;
    end else if (pump_event) begin
      next_state.sync_down = 1'b1;
    end
    // a fresh request that drops sync select must not leave it set
    if (load_function || load_initialize) begin
      if (!state.shifter[synth_function_pkg::POS_POWERDOWN_REQUEST] ||
          !state.shifter[synth_function_pkg::POS_POWERDOWN_SYNC]) begin
        next_state.sync_down = 1'b0;
      end
    end

    // timeout counter runs once per detector cycle
    if (state.timer_running && detector_tick) begin
      next_state.timeout_count = state.timeout_count -
        synth_function_pkg::TIMEOUT_WIDTH'(1);
      if (timer_expired) begin
        next_state.timer_running = 1'b0;
      end
    end
    // expiry drops the boost on its own
    if (timer_expired && timer_mode) begin
      next_state.gain_boost = 1'b0;
    end
    // leaving mode two stops the timer
    if (!timer_mode) begin
      next_state.timer_running = 1'b0;
    end

    // a 0 write also stops a running timer
    // host writes of gain boost; write beats expiry
    if (load_feedback) begin
      next_state.gain_boost = written_gain_boost;
      if (written_gain_boost && timer_mode) begin
        next_state.timer_running = 1'b1;
        next_state.timeout_count = timeout_load;
      end else if (!written_gain_boost) begin
        next_state.timer_running = 1'b0;
      end
    end

    // reloaded every cycle while down, so a wake starts from full count
    // power-down holds the timeout counter at load
    if (any_down) begin
      next_state.timer_running = 1'b0;
      next_state.timeout_count = timeout_load;
    end

    next_state.monitor_out = 1'b0;
    next_state.monitor_oe_n = 1'b0;
    case (monitor_field)
      synth_function_pkg::MONITOR_FLOAT: begin
        next_state.monitor_oe_n = 1'b1;
      end
      synth_function_pkg::MONITOR_LOCK_DETECT: begin
        // reads as unlocked while powered down
        next_state.monitor_out = lock_detect & ~any_down;
      end
      synth_function_pkg::MONITOR_FEEDBACK_DIV: begin
        next_state.monitor_out = feedback_div_out;
      end
      synth_function_pkg::MONITOR_HIGH: begin
        next_state.monitor_out = 1'b1;
      end
      synth_function_pkg::MONITOR_REFERENCE_DIV: begin
        next_state.monitor_out = reference_div_out;
      end
      synth_function_pkg::MONITOR_LOCK_OPEN_DRAIN: begin
        // open drain: drive low only, float for high
        next_state.monitor_out = 1'b0;
        next_state.monitor_oe_n = lock_detect & ~any_down;
      end
      synth_function_pkg::MONITOR_SERIAL_OUT: begin
        next_state.monitor_out = state.shifter[WORD_WIDTH-1];
      end
      synth_function_pkg::MONITOR_LOW: begin
        next_state.monitor_out = 1'b0;
      end
      default: begin
        next_state.monitor_oe_n = 1'b1;
      end
    endcase
  end

  // monitor pin floats from the first reset edge, so nothing is driven
  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state.shifter <= '0;
      state.function_control_word <= synth_function_pkg::FUNCTION_RESET;
      state.gain_boost <= 1'b0;
      state.sync_down <= 1'b0;
      state.timeout_count <= '0;
      state.timer_running <= 1'b0;
      state.init_pulse <= 1'b0;
      state.monitor_out <= 1'b0;
      state.monitor_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // divider holds: both from one term so they release together
  // the init pulse gives one cycle of hold, enough to reload both
  // hold bit resets both dividers
  assign reference_div_hold = counter_hold_reset | any_down | state.init_pulse;
  assign feedback_div_hold = counter_hold_reset | any_down | state.init_pulse;

  assign powered_down = any_down;

  assign lock_detect_clear = any_down;

  // pump floats when down, held or told to
  assign pump_float = any_down | pump_output_float | counter_hold_reset |
    state.init_pulse;

  // the raw flag stays visible on gain_boost_bit for the host
  // boost only counts with fast-lock enabled
  assign fastlock_active = fastlock_enable_bit & state.gain_boost;

  // the code switches in the same cycle as the boost flag
  // fast current during fast-lock, steady otherwise
  assign pump_current_code = fastlock_active ? fast_current_code :
    steady_current_code;

  assign detector_polarity_select = state.function_control_word[
    synth_function_pkg::POS_DETECTOR_POLARITY];

  assign monitor_select = monitor_field;
  assign gain_boost_bit = state.gain_boost;
  assign monitor_output_pin_out = state.monitor_out;
  assign monitor_output_pin_oe_n = state.monitor_oe_n;

endmodule // synth_function_control_latch

/* verification/synth_function_control_latch_checker.sv */
// concurrent checks on the function control latch ports
`timescale 1ns/100ps
module synth_function_control_latch_checker #(
  parameter int WORD_WIDTH = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load_enable,
  input wire logic chip_enable,
  input wire logic detector_tick,
  input wire logic pump_event,
  input wire logic reference_div_hold,
  input wire logic feedback_div_hold,
  input wire logic powered_down,
  input wire logic lock_detect_clear,
  input wire logic pump_float,
  input wire logic [2:0] pump_current_code,
  input wire logic fastlock_active,
  input wire logic monitor_output_pin_out,
  input wire logic monitor_output_pin_oe_n,
  input wire logic [2:0] monitor_select,
  input wire logic gain_boost_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // select held two cycles, so the registered mux has caught up
  sequence sel_high;
    monitor_select == 3'h3 ##1 monitor_select == 3'h3;
  endsequence
  sequence sel_float;
    monitor_select == 3'h0 ##1 monitor_select == 3'h0;
  endsequence

  // power-down and its side effects
  pin_down_a: assert property (!chip_enable |-> powered_down)
    else $error("pin low without power-down");
  down_float_a: assert property (
    powered_down |-> pump_float && lock_detect_clear)
    else $error("power-down left pump or lock detect active");
  down_hold_a: assert property (
    powered_down |-> reference_div_hold && feedback_div_hold)
    else $error("power-down left dividers running");
  hold_pair_a: assert property (
    reference_div_hold == feedback_div_hold)
    else $error("dividers held apart");
  down_cause_a: assert property (
    $rose(powered_down) && chip_enable && $past(chip_enable)
    |-> $past(pump_event) || $past(load_enable))
    else $error("power-down without load or pump event");

  // gain boost and current selection
  boost_rise_a: assert property (
    $rose(gain_boost_bit) |-> $past(load_enable))
    else $error("boost set without a load");
  boost_fall_a: assert property (
    $fell(gain_boost_bit) |-> $past(load_enable)
    || $past(detector_tick) || $past(detector_tick, 2))
    else $error("boost cleared without load or tick");
  fast_gate_a: assert property (fastlock_active |-> gain_boost_bit)
    else $error("fast-lock without boost");
  code_cause_a: assert property (!$stable(pump_current_code)
    |-> $past(load_enable) || !$stable(fastlock_active))
    else $error("pump current changed on its own");

  // monitor pin follows its select
  mon_high_a: assert property (
    sel_high |-> monitor_output_pin_out && !monitor_output_pin_oe_n)
    else $error("monitor not driven high");
  mon_float_a: assert property (sel_float |-> monitor_output_pin_oe_n)
    else $error("monitor driven while floating");
endmodule // synth_function_control_latch_checker

/* verification/serial_host_model.sv */
// host model driving the three-wire programming port
`timescale 1ns/100ps
module serial_host_model (
  input wire logic clk,
  output logic serial_clock,
  output logic serial_data,
  output logic load_enable
);
  // port idle at time zero
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    load_enable = 1'b0;
  end

  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk);
      serial_data = word[i];
      serial_clock = 1'b1;
      repeat (2) @(negedge clk);
      serial_clock = 1'b0;
      @(negedge clk);
    end
    @(negedge clk);
    load_enable = 1'b1;
    repeat (2) @(negedge clk);
    load_enable = 1'b0;
    // data not held after the word, so show its inverse
    serial_data = ~serial_data;
    repeat (2) @(negedge clk);
  endtask
endmodule // serial_host_model

/* verification/synth_function_control_latch_test.sv */
// self-checking bench for the function control latch
`timescale 1ns/100ps
module synth_function_control_latch_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic chip_enable = 1'b1;
  logic detector_tick = 1'b0;
  logic pump_event = 1'b0;
  logic lock_detect = 1'b1;
  logic reference_div_out = 1'b0;
  logic feedback_div_out = 1'b1;
  logic serial_clock, serial_data, load_enable;
  logic reference_div_hold, feedback_div_hold, powered_down;
  logic lock_detect_clear, pump_float, fastlock_active;
  logic detector_polarity_select, gain_boost_bit;
  logic monitor_output_pin_out, monitor_output_pin_oe_n;
  logic [2:0] pump_current_code, monitor_select;
  logic [23:0] base;
  int num_errors = 0;
  int compares = 0;
  int hold_cycles = 0;
  int hold_mark = 0;
  // expected pin per select with lock 1, ref 0, feedback 1, shifter msb 0
  localparam logic [7:0] MON_OE_N = 8'h21;
  localparam logic [7:0] MON_OUT = 8'h0e;
  // and again with lock 0, ref 1, feedback 0
  localparam logic [7:0] MON_OE_N_INV = 8'h01;
  localparam logic [7:0] MON_OUT_INV = 8'h18;
  localparam logic [1:0] FN = synth_function_pkg::SELECT_FUNCTION;
  localparam logic [1:0] FB = synth_function_pkg::SELECT_FEEDBACK;
  // short names for the field positions
  localparam int MON = synth_function_pkg::POS_MONITOR_SELECT_LSB;
  localparam int HOLD = synth_function_pkg::POS_COUNTER_HOLD_RESET;
  localparam int REQ = synth_function_pkg::POS_POWERDOWN_REQUEST;
  localparam int SYNC = synth_function_pkg::POS_POWERDOWN_SYNC;
  localparam int FLOAT = synth_function_pkg::POS_PUMP_OUTPUT_FLOAT;
  localparam int FL_EN = synth_function_pkg::POS_FASTLOCK_ENABLE;
  localparam int FL_MODE = synth_function_pkg::POS_FASTLOCK_MODE;
  localparam int CODE = synth_function_pkg::POS_TIMEOUT_CODE_LSB;
  localparam int BOOST = synth_function_pkg::POS_GAIN_BOOST;

  always #10 clk = ~clk;

  // cycles of divider hold, counted mid-cycle where the hold is settled
  always @(negedge clk) begin
    if (reset_n && reference_div_hold) begin
      hold_cycles++;
    end
  end

  serial_host_model i_host (.clk(clk), .serial_clock(serial_clock),
    .serial_data(serial_data), .load_enable(load_enable));

  synth_function_control_latch i_dut (.clk(clk), .reset_n(reset_n),
    .serial_clock(serial_clock), .serial_data(serial_data),
    .load_enable(load_enable), .chip_enable(chip_enable),
    .detector_tick(detector_tick), .pump_event(pump_event),
    .lock_detect(lock_detect), .reference_div_out(reference_div_out),
    .feedback_div_out(feedback_div_out),
    .reference_div_hold(reference_div_hold),
    .feedback_div_hold(feedback_div_hold), .powered_down(powered_down),
    .lock_detect_clear(lock_detect_clear), .pump_float(pump_float),
    .pump_current_code(pump_current_code),
    .fastlock_active(fastlock_active),
    .detector_polarity_select(detector_polarity_select),
    .monitor_output_pin_out(monitor_output_pin_out),
    .monitor_output_pin_oe_n(monitor_output_pin_oe_n),
    .monitor_select(monitor_select), .gain_boost_bit(gain_boost_bit));

  function automatic logic [23:0] at(input int pos, input logic [3:0] v);
    return {20'h0, v} << pos;
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected bit at %0t: got %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected code at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one word, then let the new settings land
  task automatic wr(input logic [23:0] f, input logic [1:0] sel);
    i_host.send(f | {22'h0, sel});
    repeat (3) @(negedge clk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      detector_tick = 1'b1;
      @(negedge clk);
      detector_tick = 1'b0;
      @(negedge clk);
    end
  endtask

  task automatic end_sim;
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog, about six times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(monitor_output_pin_oe_n, 1'b1);
    base = at(synth_function_pkg::POS_STEADY_CURRENT_LSB, 4'h5)
      | at(synth_function_pkg::POS_FAST_CURRENT_LSB, 4'h2)
      | at(synth_function_pkg::POS_DETECTOR_POLARITY, 4'h1);
    // every monitor select code, then with the watched signals flipped
    for (int m = 0; m < 8; m++) begin
      wr(base | at(MON, m[3:0]), FN);
      chk_code(monitor_select, m[2:0]);
      chk_bit(monitor_output_pin_oe_n, MON_OE_N[m]);
      if (!MON_OE_N[m]) begin
        chk_bit(monitor_output_pin_out, MON_OUT[m]);
      end
      // a wrong choice cannot hide behind equal levels
      lock_detect = 1'b0;
      reference_div_out = 1'b1;
      feedback_div_out = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(monitor_output_pin_oe_n, MON_OE_N_INV[m]);
      if (!MON_OE_N_INV[m]) begin
        chk_bit(monitor_output_pin_out, MON_OUT_INV[m]);
      end
      lock_detect = 1'b1;
      reference_div_out = 1'b0;
      feedback_div_out = 1'b1;
    end
    chk_bit(detector_polarity_select, 1'b1);
    chk_code(pump_current_code, 3'h5);
    // a reference word must leave the function fields alone
    wr(at(MON, 4'h3), 2'h0);
    chk_code(monitor_select, 3'h7);
    wr(base | at(HOLD, 4'h1), FN);
    chk_bit(reference_div_hold, 1'b1);
    chk_bit(feedback_div_hold, 1'b1);
    wr(base, FN);
    chk_bit(reference_div_hold, 1'b0);
    chk_bit(feedback_div_hold, 1'b0);
    wr(base | at(FLOAT, 4'h1), FN);
    chk_bit(pump_float, 1'b1);
    wr(base, FN);
    chk_bit(pump_float, 1'b0);
    // initialize word: fields load and the dividers get one hold cycle
    hold_mark = hold_cycles;
    wr(base | at(MON, 4'h2), 2'h3);
    chk_code(monitor_select, 3'h2);
    chk_code(3'(hold_cycles - hold_mark), 3'h1);
    chk_bit(feedback_div_hold, 1'b0);
    // enable pin low, serial port still loading
    chip_enable = 1'b0;
    @(negedge clk);
    chk_bit(powered_down, 1'b1);
    chk_bit(lock_detect_clear, 1'b1);
    chk_bit(reference_div_hold, 1'b1);
    wr(base | at(MON, 4'h3), FN);
    chk_code(monitor_select, 3'h3);
    chip_enable = 1'b1;
    @(negedge clk);
    chk_bit(powered_down, 1'b0);
    wr(base | at(REQ, 4'h1), FN);
    chk_bit(powered_down, 1'b1);
    wr(base, FN);
    chk_bit(powered_down, 1'b0);
    wr(base | at(REQ, 4'h1) | at(SYNC, 4'h1), FN);
    chk_bit(powered_down, 1'b0);
    pump_event = 1'b1;
    @(negedge clk);
    pump_event = 1'b0;
    @(negedge clk);
    chk_bit(powered_down, 1'b1);
    chk_bit(pump_float, 1'b1);
    // manual exit fast-lock ignores the timer
    wr(base | at(FL_EN, 4'h1), FN);
    wr(at(BOOST, 4'h1), FB);
    chk_code(pump_current_code, 3'h2);
    tick(70);
    chk_bit(fastlock_active, 1'b1);
    wr(24'h0, FB);
    chk_code(pump_current_code, 3'h5);
    chk_bit(gain_boost_bit, 1'b0);
    wr(base, FN);
    wr(at(BOOST, 4'h1), FB);
    chk_bit(fastlock_active, 1'b0);
    chk_code(pump_current_code, 3'h5);
    wr(24'h0, FB);
    // timer exit at both ends of the code range
    for (int c = 0; c < 16; c += 15) begin
      wr(base | at(FL_EN, 4'h1) | at(FL_MODE, 4'h1) | at(CODE, c[3:0]),
        FN);
      wr(at(BOOST, 4'h1), FB);
      tick(2 + 4 * c);
      chk_bit(fastlock_active, 1'b1);
      chk_bit(gain_boost_bit, 1'b1);
      tick(1);
      chk_bit(gain_boost_bit, 1'b0);
      chk_code(pump_current_code, 3'h5);
    end
    end_sim();
  end
endmodule // synth_function_control_latch_test

bind synth_function_control_latch synth_function_control_latch_checker #(
  .WORD_WIDTH(WORD_WIDTH)
) i_chk (.clk(clk), .reset_n(reset_n), .load_enable(load_enable),
  .chip_enable(chip_enable), .detector_tick(detector_tick),
  .pump_event(pump_event), .reference_div_hold(reference_div_hold),
  .feedback_div_hold(feedback_div_hold), .powered_down(powered_down),
  .lock_detect_clear(lock_detect_clear), .pump_float(pump_float),
  .pump_current_code(pump_current_code),
  .fastlock_active(fastlock_active),
  .monitor_output_pin_out(monitor_output_pin_out),
  .monitor_output_pin_oe_n(monitor_output_pin_oe_n),
  .monitor_select(monitor_select), .gain_boost_bit(gain_boost_bit));
